// ===== pmcd_map.svh
// Register map, field codes and timing constants of the power and clock
// controller. Assumes a 32-bit APB word per register and a 10 MHz clock.
`ifndef PMCD_MAP_SVH
`define PMCD_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define PMCD_OFS_PWRCTL  8'h00
`define PMCD_OFS_DIV     8'h04
`define PMCD_OFS_PENABLE 8'h08
`define PMCD_OFS_VECMAP  8'h0c
`define PMCD_OFS_EXTMODE 8'h10
`define PMCD_OFS_EXTWAKE 8'h14
`define PMCD_OFS_STAT    8'h18
`define PMCD_OFS_MASK    8'h1c
`define PMCD_OFS_RTCSRC  8'h20

// ****************************************************************
// Fields and codes
// ****************************************************************
`define PMCD_BIT_IDLE   0
`define PMCD_BIT_PDOWN  1
`define PMCD_DIV_QTR    2'h0
`define PMCD_DIV_FULL   2'h1
`define PMCD_DIV_HALF   2'h2
`define PMCD_N_EXT      9
`define PMCD_N_GRP      4
`define PMCD_BIT_CAP    9
`define PMCD_BIT_WAKE   10
`define PMCD_N_STAT     11

// ****************************************************************
// Timing
// ****************************************************************
`define PMCD_CLK_NS     100
`define PMCD_WAKE_NS    6400
`define PMCD_WAKE_CYC   ((`PMCD_WAKE_NS + `PMCD_CLK_NS - 1) / `PMCD_CLK_NS)

`endif

// ===== pmcd_pkg.sv
// Types shared by the power and clock controller.
// Assumes pmcd_map.svh carries all numeric constants.
package pmcd_pkg;
    // Power state of the chip
    typedef enum logic [1:0] {
        PMCD_RUN,
        PMCD_IDLE,
        PMCD_PDOWN,
        PMCD_WAKEUP
    } pmcd_state_t;
endpackage : pmcd_pkg

// ===== pmcd_top.sv
// Power mode, wake-up and peripheral clock divider controller with APB.
// Assumes I_CLK is an always-on clock; clock enables gate the rest.
// Operation
// - Idle halts execution until reset or interrupt
// - Idle stops cpu, memory, bus clocks only
// - Power-down stops the main oscillator
// - Power-down keeps state and holds pins
// - Reset or clockless interrupt ends power-down
// - RTC runs in power-down on 32 kHz
// - Software gates each peripheral clock separately
// - Peripheral clock at full, half, quarter rate
// - Divider resets to quarter rate
// - PLL stays running during idle
// - Nine edge/level inputs, four request lines
// - Each external input can enable wake-up
// - Capture inputs interrupt but never wake
// - Vector area mapped to flash or SRAM
// - Wake-up timer delays execution after power-down
`timescale 1ns/1ps
`default_nettype none
`include "pmcd_map.svh"

module pmcd_top
    import pmcd_pkg::*;
#(
    parameter int N_PERIPH = 8                       // Gated peripherals
) (
    input  wire logic                I_CLK,          // 10 MHz clock
    input  wire logic                I_RST_B,        // Sync reset, low
    input  wire logic                I_PSEL,         // APB select
    input  wire logic                I_PENABLE,      // APB enable
    input  wire logic                I_PWRITE,       // APB write
    input  wire logic [7:0]          I_PADDR,        // APB byte address
    input  wire logic [31:0]         I_PWDATA,       // APB write data
    output logic      [31:0]         O_PRDATA,       // APB read data
    output logic                     O_PREADY,       // APB ready
    output logic                     O_PSLVERR,      // APB error
    input  wire logic [8:0]          I_EXT_IN,       // External int pins
    input  wire logic                I_CAP_EVT,      // Capture event
    input  wire logic                I_PERIPH_IRQ,   // Other periph irq
    output logic                     O_CPU_CLOCK_EN, // cpu/mem/bus clock
    output logic                     O_OSC_EN,       // Main oscillator
    output logic                     O_PIN_HOLD,     // Freeze out pins
    output logic                     O_PLL_KEEP,     // Keep PLL running
    output logic                     O_PCLK_EN,      // Periph clock tick
    output logic [N_PERIPH-1:0]      O_PERIPH_CLK_EN,// Per-periph gate
    output logic                     O_RTC_EXT_CLK,  // RTC on 32 kHz
    output logic                     O_RTC_CLK_EN,   // RTC clock runs
    output logic                     O_VEC_SRAM,     // Vectors in SRAM
    output logic [3:0]               O_EXT_IRQ,      // Request lines
    output logic                     O_IRQ           // Summary interrupt
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam int WAKE_CYC = `PMCD_WAKE_CYC;         // Wake-up timer
    pmcd_state_t               state;                 // Power state
    logic [1:0]                ctrl;                  // Idle/pd bits
    logic [1:0]                div;                   // Divider code
    logic [1:0]                div_cnt;               // Divider count
    logic [N_PERIPH-1:0]       periph_en;             // Periph gates
    logic                      vec_sram;              // Vector map
    logic [8:0]                ext_edge;              // 1 = edge mode
    logic [8:0]                ext_wake;              // Wake enables
    logic [8:0]                ext_prev;              // Last pin level
    logic [`PMCD_N_STAT-1:0]   stat;                  // Sticky status
    logic [`PMCD_N_STAT-1:0]   mask;                  // Interrupt mask
    logic [`PMCD_N_STAT-1:0]   stat_set;              // Events
    logic                      rtc_sel;               // RTC source
    logic [15:0]               wake_cnt;              // Timer count
    logic                      wr;                    // Write strobe
    logic                      setup;                 // Setup phase
    logic                      wake_src;              // Clockless wake
    logic                      wake_done;             // Timer expired
    logic [31:0]               next_rdata;            // Read mux
    logic                      next_err;              // Unmapped addr

    assign wr        = I_PSEL && I_PENABLE && I_PWRITE;
    assign setup     = I_PSEL && !I_PENABLE;
    // wake enables
    // Level detect only: edges need a clock, which is stopped.
    assign wake_src  = |(I_EXT_IN & ext_wake);
    assign wake_done = (wake_cnt == 16'(WAKE_CYC - 1));

    // ****************************************************************
    // APB slave: zero wait, data registered in setup phase
    // ****************************************************************
    assign O_PREADY = 1'b1;

    // Read multiplexer and address decode
    always_comb begin
        next_rdata = 32'h0;
        next_err   = 1'b0;
        case (I_PADDR)
            `PMCD_OFS_PWRCTL:  next_rdata = {30'h0, ctrl};
            `PMCD_OFS_DIV:     next_rdata = {30'h0, div};
            `PMCD_OFS_PENABLE: next_rdata = 32'(periph_en);
            `PMCD_OFS_VECMAP:  next_rdata = {31'h0, vec_sram};
            `PMCD_OFS_EXTMODE: next_rdata = {23'h0, ext_edge};
            `PMCD_OFS_EXTWAKE: next_rdata = {23'h0, ext_wake};
            `PMCD_OFS_STAT:    next_rdata = {21'h0, stat};
            `PMCD_OFS_MASK:    next_rdata = {21'h0, mask};
            `PMCD_OFS_RTCSRC:  next_rdata = {31'h0, rtc_sel};
            default:           next_err   = 1'b1;
        endcase
    end

    // Read data and error held from setup into access phase
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            O_PRDATA  <= 32'h0;
            O_PSLVERR <= 1'b0;
        end else if (setup) begin
            O_PRDATA  <= I_PWRITE ? 32'h0 : next_rdata;
            O_PSLVERR <= next_err;
        end
    end

    // ****************************************************************
    // Plain configuration registers
    // ****************************************************************
    // Software settings; unmapped writes are dropped
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            div       <= `PMCD_DIV_QTR;
            periph_en <= '1;
            vec_sram  <= 1'b0;
            ext_edge  <= 9'h0;
            ext_wake  <= 9'h0;
            mask      <= '0;
            rtc_sel   <= 1'b0;
        end else if (wr) begin
            case (I_PADDR)
                // ratio select; code 3 behaves as quarter
                `PMCD_OFS_DIV:     div       <= I_PWDATA[1:0];
                `PMCD_OFS_PENABLE: periph_en <= I_PWDATA[N_PERIPH-1:0];
                `PMCD_OFS_VECMAP:  vec_sram  <= I_PWDATA[0];
                `PMCD_OFS_EXTMODE: ext_edge  <= I_PWDATA[8:0];
                `PMCD_OFS_EXTWAKE: ext_wake  <= I_PWDATA[8:0];
                `PMCD_OFS_MASK:    mask <= I_PWDATA[`PMCD_N_STAT-1:0];
                `PMCD_OFS_RTCSRC:  rtc_sel   <= I_PWDATA[0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Power state machine
    // ****************************************************************
    // Mode bits: software sets, hardware clears on exit
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            ctrl <= 2'h0;
        end else if (state == PMCD_IDLE && O_IRQ) begin
            ctrl[`PMCD_BIT_IDLE] <= 1'b0;
        end else if (state == PMCD_WAKEUP && wake_done) begin
            ctrl <= 2'h0;
        end else if (wr && I_PADDR == `PMCD_OFS_PWRCTL) begin
            ctrl <= I_PWDATA[1:0];
        end
    end

    // Mode transitions; power-down wins if both bits are set
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            state <= PMCD_RUN;
        end else begin
            case (state)
                PMCD_RUN: begin
                    if (ctrl[`PMCD_BIT_PDOWN])
                        state <= PMCD_PDOWN;
                    else if (ctrl[`PMCD_BIT_IDLE])
                        state <= PMCD_IDLE;
                end
                PMCD_IDLE: if (O_IRQ) state <= PMCD_RUN;
                PMCD_PDOWN: if (wake_src) state <= PMCD_WAKEUP;
                PMCD_WAKEUP: if (wake_done) state <= PMCD_RUN;
                default: state <= PMCD_RUN;
            endcase
        end
    end

    // Wake-up timer count
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B || state != PMCD_WAKEUP)
            wake_cnt <= 16'h0;
        else
            wake_cnt <= wake_cnt + 16'h1;
    end

    assign O_CPU_CLOCK_EN = (state == PMCD_RUN);
    assign O_OSC_EN       = (state != PMCD_PDOWN);
    // pins frozen until clocks are stable again
    assign O_PIN_HOLD     = (state == PMCD_PDOWN) || (state == PMCD_WAKEUP);
    assign O_PLL_KEEP     = O_OSC_EN;
    // RTC alive in power-down only on external source
    assign O_RTC_EXT_CLK  = rtc_sel;
    assign O_RTC_CLK_EN   = rtc_sel || O_OSC_EN;
    assign O_VEC_SRAM     = vec_sram;

    // ****************************************************************
    // Peripheral clock divider
    // ****************************************************************
    // tick every 1, 2 or 4 cpu clocks; stops with the oscillator
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            div_cnt   <= 2'h0;
            O_PCLK_EN <= 1'b0;
        end else if (!O_OSC_EN) begin
            div_cnt   <= 2'h0;
            O_PCLK_EN <= 1'b0;
        end else begin
            O_PCLK_EN <= (div_cnt == 2'h0);
            if (div == `PMCD_DIV_FULL)
                div_cnt <= 2'h0;
            else if (div == `PMCD_DIV_HALF)
                div_cnt <= {1'b0, ~div_cnt[0]};
            else
                div_cnt <= div_cnt + 2'h1;
        end
    end

    // gates hold in run and idle alike
    assign O_PERIPH_CLK_EN = O_OSC_EN ? periph_en : '0;

    // ****************************************************************
    // External interrupts and status
    // ****************************************************************
    // Previous pin levels for edge detect
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B)
            ext_prev <= 9'h0;
        else
            ext_prev <= I_EXT_IN;
    end

    // edge or level event per input; edge mode ignores a held pin
    genvar g;
    generate
        for (g = 0; g < `PMCD_N_EXT; g++) begin : g_ext
            assign stat_set[g] = I_EXT_IN[g] & ~(ext_edge[g] & ext_prev[g]);
        end
    endgenerate
    assign stat_set[`PMCD_BIT_CAP]  = I_CAP_EVT;
    assign stat_set[`PMCD_BIT_WAKE] = (state == PMCD_WAKEUP) && wake_done;

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B)
            stat <= '0;
        else if (wr && I_PADDR == `PMCD_OFS_STAT)
            stat <= (stat & ~I_PWDATA[`PMCD_N_STAT-1:0]) | stat_set;
        else
            stat <= stat | stat_set;
    end

    // input i feeds request line i mod 4
    generate
        for (g = 0; g < `PMCD_N_GRP; g++) begin : g_grp
            logic [8:0] sel;
            for (genvar k = 0; k < `PMCD_N_EXT; k++) begin : g_bit
                assign sel[k] = (k % `PMCD_N_GRP) == g;
            end
            assign O_EXT_IRQ[g] = |(stat[8:0] & mask[8:0] & sel);
        end
    endgenerate

    assign O_IRQ = (|(stat & mask)) || I_PERIPH_IRQ;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_idle_core_off : assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        state == PMCD_IDLE |-> !O_CPU_CLOCK_EN && O_OSC_EN)
        else $error("core clock running in idle");
    a_idle_exit_irq : assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        state == PMCD_IDLE && O_IRQ |=> state == PMCD_RUN)
        else $error("idle not left on interrupt");
    a_pd_osc_off : assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        state == PMCD_PDOWN |-> !O_OSC_EN && O_PERIPH_CLK_EN == '0)
        else $error("clock alive in power-down");
    a_pd_pin_hold : assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        $rose(state == PMCD_PDOWN) |-> O_PIN_HOLD[*2])
        else $error("pins not held");
    a_pd_wake_go : assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        state == PMCD_PDOWN && wake_src |=> state == PMCD_WAKEUP)
        else $error("wake ignored");
    a_cap_no_wake : assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        state == PMCD_PDOWN && !wake_src |=> state == PMCD_PDOWN)
        else $error("woken without enabled pin");
    a_wake_timer_len : assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        state == PMCD_WAKEUP && wake_cnt < 16'(WAKE_CYC - 1) |=>
        state == PMCD_WAKEUP && !O_CPU_CLOCK_EN)
        else $error("wake timer cut short");
    a_ctrl_self_clr : assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        state == PMCD_WAKEUP && wake_done |=> ctrl == 2'h0 && O_CPU_CLOCK_EN)
        else $error("mode bits not cleared");
    a_div_reset_qtr : assert property (@(posedge I_CLK)
        !I_RST_B |=> div == `PMCD_DIV_QTR)
        else $error("divider not quarter after reset");
    a_div_quarter : assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        div == `PMCD_DIV_QTR && $stable(div) && O_PCLK_EN && O_OSC_EN
        ##1 $stable(div) && O_OSC_EN |-> !O_PCLK_EN)
        else $error("quarter ratio wrong");
    a_rtc_pd_src : assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        state == PMCD_PDOWN |-> O_RTC_CLK_EN == rtc_sel)
        else $error("rtc clock wrong in power-down");
    a_pll_idle_on : assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        state == PMCD_IDLE |-> O_PLL_KEEP)
        else $error("pll dropped in idle");
    a_vec_map_wr : assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        wr && I_PADDR == `PMCD_OFS_VECMAP |=> O_VEC_SRAM == $past(I_PWDATA[0]))
        else $error("vector map not updated");

    c_idle_cycle : cover property (@(posedge I_CLK) disable iff (!I_RST_B)
        state == PMCD_IDLE ##[1:50] state == PMCD_RUN);
    c_pd_wake : cover property (@(posedge I_CLK) disable iff (!I_RST_B)
        state == PMCD_WAKEUP && wake_done);
    c_stat_race : cover property (@(posedge I_CLK) disable iff (!I_RST_B)
        wr && I_PADDR == `PMCD_OFS_STAT && |stat_set);
    c_half_rate : cover property (@(posedge I_CLK) disable iff (!I_RST_B)
        div == `PMCD_DIV_HALF && O_PCLK_EN);

endmodule : pmcd_top

`default_nettype wire

// ===== pmcd_top_tb.sv
// Self-checking bench for the power mode and clock divider controller.
// Assumes pmcd_map.svh offsets and a single 10 MHz always-on clock.
`timescale 1ns/1ps
`default_nettype none
`include "pmcd_map.svh"

module pmcd_top_tb
    import pmcd_pkg::*;
;
    // ************************************************************
    // Signals and clock
    // ************************************************************
    typedef struct {
        logic [7:0]  a;                     // Register offset
        logic [31:0] d;                     // Write value
        logic [31:0] x;                     // Expected read back
    } pmcd_row_t;
    logic        clk     = 1'b0;            // Bench clock
    logic        rst_b   = 1'b0;            // Sync reset, low
    logic        psel    = 1'b0;            // APB select
    logic        penable = 1'b0;            // APB enable
    logic        pwrite  = 1'b0;            // APB direction
    logic [7:0]  paddr   = 8'h00;           // APB address
    logic [31:0] pwdata  = 32'h0;           // APB write data
    logic [8:0]  ext_in  = 9'h000;          // External pins
    logic        cap_evt = 1'b0;            // Capture event
    logic        p_irq   = 1'b0;            // Other peripheral irq
    logic [31:0] prdata;                    // Read data
    logic        pready, pslverr;           // APB answer
    logic        cpu_en, osc_en, hold, pll, pclk, rtc_ext, rtc_en, vsram;
    logic        irq;                       // Summary interrupt
    logic [7:0]  per_en;                    // Peripheral gates
    logic [3:0]  ext_irq;                   // Request lines
    int          fail_count = 0;            // Mismatches
    int          cmp_count  = 0;            // Comparisons
    pmcd_row_t   rows[7];                   // Register table cases

    // Half period of 50 ns gives 10 MHz
    initial begin
        forever #50 clk = ~clk;
    end

    pmcd_top #(.N_PERIPH(8)) DUT (
        .I_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_EXT_IN(ext_in), .I_CAP_EVT(cap_evt), .I_PERIPH_IRQ(p_irq),
        .O_CPU_CLOCK_EN(cpu_en), .O_OSC_EN(osc_en), .O_PIN_HOLD(hold),
        .O_PLL_KEEP(pll), .O_PCLK_EN(pclk), .O_PERIPH_CLK_EN(per_en),
        .O_RTC_EXT_CLK(rtc_ext), .O_RTC_CLK_EN(rtc_en),
        .O_VEC_SRAM(vsram), .O_EXT_IRQ(ext_irq), .O_IRQ(irq)
    );

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask : rd

    // Count peripheral clock ticks over a window of cycles
    task automatic ticks(input int cyc, output int n);
        n = 0;
        repeat (2) @(negedge clk);
        repeat (cyc) begin
            @(negedge clk);
            n += (pclk === 1'b1) ? 1 : 0;
        end
    endtask : ticks

    // Wait for the cpu clock to return, counting cycles
    task automatic wait_run(output int n);
        n = 0;
        while (cpu_en !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_run

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    // Watchdog: whole run is a few hundred cycles, allow far more
    initial begin
        #3_000_000;
        fail_count++;
        end_sim();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        int n;
        int exp_t[4];
        logic [31:0] r;
        logic        e;
        exp_t = '{4, 16, 8, 4};
        rows = '{'{`PMCD_OFS_PENABLE, 32'hffff_ff5a, 32'h5a},
                 '{`PMCD_OFS_VECMAP,  32'hffff_ffff, 32'h1},
                 '{`PMCD_OFS_EXTMODE, 32'hffff_fe21, 32'h021},
                 '{`PMCD_OFS_EXTWAKE, 32'h0000_0020, 32'h020},
                 '{`PMCD_OFS_MASK,    32'hffff_ffff, 32'h7ff},
                 '{`PMCD_OFS_RTCSRC,  32'hffff_ffff, 32'h1},
                 '{`PMCD_OFS_DIV,     32'hffff_ffff, 32'h3}};
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk({cpu_en, osc_en, hold, vsram}, 32'hc);
        chk(per_en, 32'hff);
        rd(`PMCD_OFS_DIV, 32'h0);
        ticks(16, n);
        chk(n, 32'd4);
        $display("reset test done");
        // Table of register writes and read backs
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].x);
        end
        chk({per_en, vsram, rtc_ext}, {8'h5a, 2'b11});
        $display("register table done");
        // Every divider code; code 3 behaves as quarter
        for (int c = 0; c < 4; c++) begin
            wr(`PMCD_OFS_DIV, c);
            ticks(16, n);
            chk(n, exp_t[c]);
        end
        $display("divider test done");
        // Unmapped address is refused both ways; error bit checked apart
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk(r, 32'h0);
        chk(e, 1'b1);
        apb(1'b1, 8'h40, 32'h1, r, e);
        chk(e, 1'b1);
        apb(1'b0, `PMCD_OFS_VECMAP, 32'h0, r, e);
        chk(r, 32'h1);
        chk(e, 1'b0);
        // Edge pins 0 and 5 rise: two request lines
        ext_in[0] <= 1'b1;
        ext_in[5] <= 1'b1;
        @(posedge clk);
        ext_in[0] <= 1'b0;
        repeat (3) @(negedge clk);
        chk({irq, ext_irq}, 32'h13);
        // Pin 5 still high: edge mode must not set it again after clear
        wr(`PMCD_OFS_STAT, 32'hffff_ffff);
        rd(`PMCD_OFS_STAT, 32'h0);
        ext_in[5] <= 1'b0;
        chk(irq, 1'b0);
        // Level pin 1 held high sets its bit again, even against a clear
        ext_in[1] <= 1'b1;
        wr(`PMCD_OFS_STAT, 32'h2);
        rd(`PMCD_OFS_STAT, 32'h2);
        ext_in[1] <= 1'b0;
        wr(`PMCD_OFS_STAT, 32'h2);
        // Masked event sets status but raises no interrupt
        wr(`PMCD_OFS_MASK, 32'h0);
        cap_evt <= 1'b1;
        @(posedge clk);
        cap_evt <= 1'b0;
        rd(`PMCD_OFS_STAT, 32'h200);
        chk(irq, 1'b0);
        wr(`PMCD_OFS_STAT, 32'h200);
        $display("interrupt test done");
        // Idle: cpu clock stops, oscillator, PLL and pclk keep going
        wr(`PMCD_OFS_PWRCTL, 32'h1);
        ticks(16, n);
        chk({cpu_en, osc_en, pll}, 32'h3);
        chk(n, 32'd4);
        @(posedge clk);
        p_irq <= 1'b1;
        repeat (4) @(negedge clk);
        chk(cpu_en, 1'b1);
        @(posedge clk);
        p_irq <= 1'b0;
        rd(`PMCD_OFS_PWRCTL, 32'h0);
        $display("idle test done");
        // Power-down: capture and non-wake pin must not wake
        wr(`PMCD_OFS_PWRCTL, 32'h2);
        repeat (3) @(negedge clk);
        chk({cpu_en, osc_en, pll, hold, rtc_en}, 32'h3);
        @(posedge clk);
        cap_evt <= 1'b1;
        ext_in[4] <= 1'b1;
        repeat (2) @(posedge clk);
        cap_evt <= 1'b0;
        ext_in[4] <= 1'b0;
        repeat (10) @(negedge clk);
        chk({cpu_en, osc_en}, 32'h0);
        @(posedge clk);
        ext_in[5] <= 1'b1;
        wait_run(n);
        chk(n >= `PMCD_WAKE_CYC && n <= `PMCD_WAKE_CYC + 4, 1'b1);
        chk({osc_en, hold}, 32'h2);
        @(posedge clk);
        ext_in[5] <= 1'b0;
        rd(`PMCD_OFS_PWRCTL, 32'h0);
        apb(1'b0, `PMCD_OFS_STAT, 32'h0, r, e);
        chk(r & 32'h630, 32'h630);
        wr(`PMCD_OFS_STAT, 32'hffff_ffff);
        // RTC on peripheral clock stops in power-down
        wr(`PMCD_OFS_RTCSRC, 32'h0);
        wr(`PMCD_OFS_PWRCTL, 32'h3);
        repeat (3) @(negedge clk);
        chk({rtc_en, osc_en, rtc_ext}, 32'h0);
        @(posedge clk);
        ext_in[5] <= 1'b1;
        wait_run(n);
        chk(n >= `PMCD_WAKE_CYC && n <= `PMCD_WAKE_CYC + 4, 1'b1);
        @(posedge clk);
        ext_in[5] <= 1'b0;
        rd(`PMCD_OFS_PWRCTL, 32'h0);
        $display("power-down test done");
        // Reset in mid-run restores the quarter rate and gates
        wr(`PMCD_OFS_DIV, 32'h1);
        wr(`PMCD_OFS_PENABLE, 32'h0);
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd(`PMCD_OFS_DIV, 32'h0);
        chk(per_en, 32'hff);
        ticks(16, n);
        chk(n, 32'd4);
        $display("second reset test done");
        end_sim();
    end
endmodule : pmcd_top_tb

`default_nettype wire
